// *** verilog/dpdrh_pkg.sv ***
// Constants, register map and types for the debug probe detect and reset hold block
package dpdrh_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam int ADDR_W = 13;
    localparam logic [12:0] STATUS_A_OFS = 13'h0100;
    localparam logic [12:0] STATUS_B_OFS = 13'h0104;
    localparam logic [12:0] SMEM_OFS = 13'h0108;
    localparam logic [12:0] IRQ_STAT_OFS = 13'h010C;
    localparam logic [12:0] IRQ_CLR_OFS = 13'h0110;
    localparam logic [12:0] IRQ_EN_OFS = 13'h0114;
    localparam logic [12:0] PERIPH_ID4_OFS = 13'h1FD0;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int HOLD_BIT = 0;
    localparam int PROT_ERR_BIT = 1;
    localparam int COLD_BIT = 2;
    localparam int HPA_BIT = 0;
    localparam int HSEEN_BIT = 1;
    localparam int SMEM_BIT = 0;
    localparam int EV_HOT = 0;
    localparam int EV_PROT_ERR = 1;
    localparam int EV_COLD = 2;
    localparam int EV_W = 3;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [EV_W-1:0] IRQ_EN_RST = 3'h0;
    localparam logic PULL_RST = 1'b1;
    localparam logic HPA_RST = 1'b1;
    localparam logic SYNC_RST = 1'b1;
    // Synchroniser fill time before the pin level is trusted at release
    localparam logic [1:0] BOOT_CYCLES = 2'h2;
    // Arbitrary identification value
    localparam logic [31:0] PERIPH_ID4_DEFAULT = 32'h0000_0042;

    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN = 2'b10
    } dpdrh_state_e;
endpackage

// *** verilog/dpdrh_sync.sv ***
// Two-flop synchroniser for the debug clock pin
module dpdrh_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta;

    // Pin idles high through the pull-up, so reset to high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= dpdrh_pkg::SYNC_RST;
            q <= dpdrh_pkg::SYNC_RST;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // dpdrh_sync

// *** verilog/dpdrh_fall_det.sv ***
// Falling-edge detector with enable, one-cycle registered pulse
module dpdrh_fall_det (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic d,
    output logic fall
);
    logic prev;
    logic next_fall;

    always_comb begin
        next_fall = en && prev && !d;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= dpdrh_pkg::SYNC_RST;
            fall <= 1'b0;
        end else begin
            prev <= d;
            fall <= next_fall;
        end
    end
endmodule // dpdrh_fall_det

// *** verilog/dpdrh_top.sv ***
// Debug probe detection, CPU reset-extension hold and AHB-Lite register file
//
// Chosen here: the AHB-Lite register port.
module dpdrh_top #(
    parameter logic [31:0] PERIPH_ID4_VALUE = dpdrh_pkg::PERIPH_ID4_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic swclk_pin,
    input wire logic security_lock,
    input wire logic pad_reassigned,
    output logic swclk_pull_en,
    output logic cpu_hold,
    output logic irq
);
    // ****************************************
    // Declarations
    // ****************************************
    logic dp_wr;
    logic [12:0] dp_addr;
    logic next_dp_wr;
    logic [12:0] next_dp_addr;
    logic [31:0] next_hrdata;
    logic [31:0] rd_word;
    logic addr_ok;
    logic wr_a;
    logic wr_b;
    logic wr_clr;
    logic wr_en;

    dpdrh_pkg::dpdrh_state_e state;
    dpdrh_pkg::dpdrh_state_e next_state;
    logic [1:0] boot_cnt;
    logic [1:0] next_boot_cnt;
    logic protect_error;
    logic next_protect_error;
    logic cold_plug;
    logic next_cold_plug;
    logic hotplug_available;
    logic next_hotplug_available;
    logic hotplug_seen;
    logic next_hotplug_seen;
    logic sys_mem_present;
    logic next_sys_mem_present;
    logic next_cpu_hold;
    logic cpu_hold_ext;
    logic boot_done;
    logic rel_try;

    logic [dpdrh_pkg::EV_W-1:0] irq_stat;
    logic [dpdrh_pkg::EV_W-1:0] irq_en;
    logic [dpdrh_pkg::EV_W-1:0] next_irq_stat;
    logic [dpdrh_pkg::EV_W-1:0] next_irq_en;
    logic [dpdrh_pkg::EV_W-1:0] ev;
    logic next_irq;

    logic swclk_s;
    logic hp_en;
    logic hp_fall;

    // ****************************************
    // Debug clock pin conditioning
    // ****************************************
    // Pin is asynchronous to hclk
    dpdrh_sync u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d(swclk_pin),
        .q(swclk_s)
    );

    // No edges counted before the synchroniser has filled after release
    assign hp_en = hotplug_available && (state != dpdrh_pkg::ST_BOOT);

    // Detector shares the system reset, so nothing is seen during reset
    dpdrh_fall_det u_fall (
        .clk(hclk),
        .rst_n(hresetn),
        .en(hp_en),
        .d(swclk_s),
        .fall(hp_fall)
    );

    // ****************************************
    // AHB-Lite slave, zero wait states
    // ****************************************
    assign addr_ok = hsel && hready && htrans[1];

    // Read data is taken in the address phase and registered, so a read
    // right behind a write to the same register sees the old value
    always_comb begin
        rd_word = 32'h0;
        case (haddr[12:0])
            dpdrh_pkg::STATUS_A_OFS: begin
                rd_word[dpdrh_pkg::HOLD_BIT] = cpu_hold_ext;
                rd_word[dpdrh_pkg::PROT_ERR_BIT] = protect_error;
                rd_word[dpdrh_pkg::COLD_BIT] = cold_plug;
            end
            dpdrh_pkg::STATUS_B_OFS: begin
                rd_word[dpdrh_pkg::HPA_BIT] = hotplug_available;
                rd_word[dpdrh_pkg::HSEEN_BIT] = hotplug_seen;
            end
            dpdrh_pkg::SMEM_OFS: begin
                rd_word[dpdrh_pkg::SMEM_BIT] = sys_mem_present;
            end
            dpdrh_pkg::IRQ_STAT_OFS: begin
                rd_word[dpdrh_pkg::EV_W-1:0] = irq_stat;
            end
            dpdrh_pkg::IRQ_EN_OFS: begin
                rd_word[dpdrh_pkg::EV_W-1:0] = irq_en;
            end
            dpdrh_pkg::PERIPH_ID4_OFS: begin
                rd_word = PERIPH_ID4_VALUE;
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    always_comb begin
        next_dp_wr = addr_ok && hwrite;
        next_dp_addr = addr_ok ? haddr[12:0] : dp_addr;
        next_hrdata = (addr_ok && !hwrite) ? rd_word : 32'h0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_addr <= 13'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dp_wr <= next_dp_wr;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Writes act in the data phase; read-only offsets ignore writes
    assign wr_a = dp_wr && (dp_addr == dpdrh_pkg::STATUS_A_OFS);
    assign wr_b = dp_wr && (dp_addr == dpdrh_pkg::STATUS_B_OFS);
    assign wr_clr = dp_wr && (dp_addr == dpdrh_pkg::IRQ_CLR_OFS);
    assign wr_en = dp_wr && (dp_addr == dpdrh_pkg::IRQ_EN_OFS);

    // ****************************************
    // Reset extension and probe detection
    // ****************************************
    assign cpu_hold_ext = (state == dpdrh_pkg::ST_HOLD);
    assign boot_done = (state == dpdrh_pkg::ST_BOOT) && (boot_cnt == dpdrh_pkg::BOOT_CYCLES);
    assign rel_try = wr_a && hwdata[dpdrh_pkg::HOLD_BIT];

    always_comb begin
        next_state = state;
        next_boot_cnt = boot_cnt;
        next_protect_error = protect_error;
        next_cold_plug = cold_plug;
        next_hotplug_available = hotplug_available;
        next_hotplug_seen = hotplug_seen;
        next_sys_mem_present = sys_mem_present;
        ev = '0;
        // Software clears first so a same-cycle set wins
        if (wr_a && hwdata[dpdrh_pkg::PROT_ERR_BIT]) begin
            next_protect_error = 1'b0;
        end
        if (wr_b && hwdata[dpdrh_pkg::HSEEN_BIT]) begin
            next_hotplug_seen = 1'b0;
        end
        case (state)
            dpdrh_pkg::ST_BOOT: begin
                if (boot_done) begin
                    next_sys_mem_present = !security_lock;
                    if (!swclk_s) begin
                        next_state = dpdrh_pkg::ST_HOLD;
                        next_cold_plug = 1'b1;
                        ev[dpdrh_pkg::EV_COLD] = 1'b1;
                    end else begin
                        next_state = dpdrh_pkg::ST_RUN;
                    end
                end else begin
                    next_boot_cnt = boot_cnt + 2'h1;
                end
            end
            dpdrh_pkg::ST_HOLD: begin
                if (rel_try) begin
                    if (security_lock) begin
                        next_protect_error = 1'b1;
                        ev[dpdrh_pkg::EV_PROT_ERR] = 1'b1;
                    end else begin
                        next_state = dpdrh_pkg::ST_RUN;
                    end
                end
            end
            dpdrh_pkg::ST_RUN: begin
                next_state = dpdrh_pkg::ST_RUN;
            end
            default: begin
                next_state = dpdrh_pkg::ST_HOLD;
            end
        endcase
        // Only a reset brings the detector back
        if (pad_reassigned) begin
            next_hotplug_available = 1'b0;
        end
        if (hp_fall) begin
            next_hotplug_seen = 1'b1;
            ev[dpdrh_pkg::EV_HOT] = 1'b1;
        end
        next_cpu_hold = (next_state != dpdrh_pkg::ST_RUN);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= dpdrh_pkg::ST_BOOT;
            boot_cnt <= 2'h0;
            protect_error <= 1'b0;
            cold_plug <= 1'b0;
            hotplug_available <= dpdrh_pkg::HPA_RST;
            hotplug_seen <= 1'b0;
            sys_mem_present <= 1'b0;
            cpu_hold <= 1'b1;
            swclk_pull_en <= dpdrh_pkg::PULL_RST;
        end else begin
            state <= next_state;
            boot_cnt <= next_boot_cnt;
            protect_error <= next_protect_error;
            cold_plug <= next_cold_plug;
            hotplug_available <= next_hotplug_available;
            hotplug_seen <= next_hotplug_seen;
            sys_mem_present <= next_sys_mem_present;
            cpu_hold <= next_cpu_hold;
            swclk_pull_en <= dpdrh_pkg::PULL_RST;
        end
    end

    // ****************************************
    // Interrupt status, clear and enable
    // ****************************************
    always_comb begin
        next_irq_en = wr_en ? hwdata[dpdrh_pkg::EV_W-1:0] : irq_en;
        next_irq_stat = irq_stat;
        if (wr_clr) begin
            next_irq_stat = irq_stat & ~hwdata[dpdrh_pkg::EV_W-1:0];
        end
        next_irq_stat = next_irq_stat | ev;
        next_irq = |(next_irq_stat & next_irq_en);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
            irq_en <= dpdrh_pkg::IRQ_EN_RST;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            irq <= next_irq;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking dck @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_COLD_HOLD: assert property (
        boot_done && !swclk_s |=> cpu_hold_ext && cpu_hold && cold_plug
    ) else $error("Low pin at release did not hold the core");

    AST_PULL_UP: assert property (
        swclk_pull_en
    ) else $error("Debug clock pull-up not enabled");

    AST_HOLD_BIT: assert property (
        cpu_hold_ext |-> cpu_hold
    ) else $error("Hold status set but core not held");

    AST_RELEASE: assert property (
        cpu_hold_ext && rel_try && !security_lock |=> !cpu_hold_ext && !cpu_hold && state == dpdrh_pkg::ST_RUN
    ) else $error("Release write did not free the core");

    AST_WRITE_ZERO: assert property (
        cpu_hold_ext && wr_a && !hwdata[dpdrh_pkg::HOLD_BIT] |=> cpu_hold_ext
    ) else $error("Writing zero changed the hold");

    AST_LOCK_KEEPS: assert property (
        cpu_hold_ext && rel_try && security_lock |=> cpu_hold_ext ##0 cpu_hold
    ) else $error("Locked device released the core");

    AST_PROT_ERR_SET: assert property (
        cpu_hold_ext && rel_try && security_lock |=> protect_error && irq_stat[dpdrh_pkg::EV_PROT_ERR]
    ) else $error("Refused release did not flag protection error");

    AST_COLD_FLAG: assert property (
        $rose(cold_plug) |-> $past(boot_done) && cpu_hold_ext
    ) else $error("Cold plug reported without a hold request");

    AST_HOT_EDGE: assert property (
        hp_en && $past(swclk_s) && !swclk_s |=> hp_fall ##1 hotplug_seen
    ) else $error("Falling debug clock edge not detected");

    AST_HP_STAYS_OFF: assert property (
        !hotplug_available |=> !hotplug_available && !hp_fall
    ) else $error("Hot-plug detection came back without reset");

    AST_HP_STATUS: assert property (
        pad_reassigned |=> !hotplug_available
    ) else $error("Pad reassignment not shown in status");

    AST_SMEM: assert property (
        boot_done |=> sys_mem_present == !$past(security_lock)
    ) else $error("Memory-present bit does not follow the lock");
endmodule // dpdrh_top

// *** verif/dpdrh_probe_model.sv ***
// Behavioural model of an external serial-wire debug probe on the debug clock pin
module dpdrh_probe_model (
    input wire logic pull_en,
    input wire logic plugged,
    input wire logic frame,
    output logic swclk
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Probe clock
    // ****************************************
    logic sck = 1'b0;

    // Runs only within frames; idle level is low so a plugged probe reads as present
    always begin
        #62.5;
        if (frame) begin
            sck = ~sck;
        end else begin
            sck = 1'b0;
        end
    end

    // ****************************************
    // Pin level
    // ****************************************
    // An unplugged pin is left to the internal pull-up
    assign swclk = plugged ? sck : pull_en;
endmodule // dpdrh_probe_model

// *** verif/dpdrh_top_tb.sv ***
// Self-checking testbench for the debug probe detect and reset hold block
module dpdrh_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Signals and constants
    // ****************************************
    // Arbitrary identification value, differs from the default to prove the override
    localparam logic [31:0] PID = 32'h0000_00A5;
    localparam logic [31:0] B_HOLD = 32'h1 << dpdrh_pkg::HOLD_BIT;
    localparam logic [31:0] B_PROT = 32'h1 << dpdrh_pkg::PROT_ERR_BIT;
    // Selects for the pin check, which must read the output after it settles
    localparam int O_HOLD = 0;
    localparam int O_PULL = 1;
    localparam int O_IRQ = 2;
    localparam logic [31:0] B_COLD = 32'h1 << dpdrh_pkg::COLD_BIT;
    localparam logic [31:0] B_HPA = 32'h1 << dpdrh_pkg::HPA_BIT;
    localparam logic [31:0] B_SEEN = 32'h1 << dpdrh_pkg::HSEEN_BIT;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, swclk_pin, swclk_pull_en, cpu_hold, irq;
    logic [31:0] hrdata;
    logic security_lock = 1'b0;
    logic pad_reassigned = 1'b0;
    logic plugged = 1'b1;
    logic frame = 1'b0;
    int errors = 0;
    int samples_checked = 0;
    logic [2:0] outs;

    assign outs = {irq, swclk_pull_en, cpu_hold};

    always #5 hclk = ~hclk;

    dpdrh_top #(.PERIPH_ID4_VALUE(PID)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .swclk_pin(swclk_pin),
        .security_lock(security_lock), .pad_reassigned(pad_reassigned), .swclk_pull_en(swclk_pull_en),
        .cpu_hold(cpu_hold), .irq(irq));

    dpdrh_probe_model probe (.pull_en(swclk_pull_en), .plugged(plugged), .frame(frame), .swclk(swclk_pin));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] ofs(input logic [12:0] o);
        return {19'h0, o};
    endfunction

    // Single AHB-Lite transfer; waits on hready in both phases
    task automatic xfer(input logic wr, input logic [12:0] o, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= ofs(o);
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [12:0] o, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, o, d, q);
    endtask

    task automatic rdchk(input logic [12:0] o, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, o, 32'h0000_0000, q);
        check(q, exp);
    endtask

    // Outputs are looked at mid-cycle, after the edge's updates have landed
    task automatic pin(input int sel, input logic exp);
        @(negedge hclk);
        check({31'h0, outs[sel]}, {31'h0, exp});
    endtask

    // Blip makes a falling pin edge while reset is held
    task automatic do_reset(input logic lock, input logic plug, input logic blip);
        @(posedge hclk);
        hresetn <= 1'b0;
        security_lock <= lock;
        plugged <= plug;
        repeat (3) @(posedge hclk);
        plugged <= plug | blip;
        repeat (2) @(posedge hclk);
        plugged <= plug;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask

    task automatic probe_frame();
        @(posedge hclk);
        plugged <= 1'b1;
        frame <= 1'b1;
        repeat (40) @(posedge hclk);
        frame <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #50us;
        errors++;
        summarize();
    end

    initial begin
        do_reset(1'b0, 1'b1, 1'b0);
        pin(O_HOLD, 1'b1);
        pin(O_PULL, 1'b1);
        rdchk(dpdrh_pkg::STATUS_A_OFS, B_HOLD | B_COLD);
        rdchk(dpdrh_pkg::SMEM_OFS, 32'h0000_0001);
        rdchk(dpdrh_pkg::PERIPH_ID4_OFS, PID);
        wr(dpdrh_pkg::PERIPH_ID4_OFS, ~PID);
        rdchk(dpdrh_pkg::PERIPH_ID4_OFS, PID);
        rdchk(13'h0F00, 32'h0000_0000);
        rdchk(dpdrh_pkg::IRQ_STAT_OFS, 32'h1 << dpdrh_pkg::EV_COLD);
        rdchk(dpdrh_pkg::IRQ_EN_OFS, 32'h0000_0000);
        pin(O_IRQ, 1'b0);
        wr(dpdrh_pkg::IRQ_EN_OFS, 32'h1 << dpdrh_pkg::EV_COLD);
        pin(O_IRQ, 1'b1);
        wr(dpdrh_pkg::IRQ_EN_OFS, 32'h0000_0000);
        pin(O_IRQ, 1'b0);
        wr(dpdrh_pkg::IRQ_EN_OFS, 32'h1 << dpdrh_pkg::EV_COLD);
        wr(dpdrh_pkg::IRQ_CLR_OFS, 32'h1 << dpdrh_pkg::EV_COLD);
        pin(O_IRQ, 1'b0);
        rdchk(dpdrh_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        wr(dpdrh_pkg::STATUS_A_OFS, 32'h0000_0000);
        pin(O_HOLD, 1'b1);
        rdchk(dpdrh_pkg::STATUS_A_OFS, B_HOLD | B_COLD);
        wr(dpdrh_pkg::STATUS_A_OFS, B_HOLD);
        pin(O_HOLD, 1'b0);
        rdchk(dpdrh_pkg::STATUS_A_OFS, B_COLD);

        // Locked device: release refused
        do_reset(1'b1, 1'b1, 1'b0);
        rdchk(dpdrh_pkg::SMEM_OFS, 32'h0000_0000);
        wr(dpdrh_pkg::IRQ_EN_OFS, 32'h1 << dpdrh_pkg::EV_PROT_ERR);
        wr(dpdrh_pkg::STATUS_A_OFS, B_HOLD);
        pin(O_IRQ, 1'b1);
        pin(O_HOLD, 1'b1);
        rdchk(dpdrh_pkg::STATUS_A_OFS, B_HOLD | B_PROT | B_COLD);
        wr(dpdrh_pkg::STATUS_A_OFS, B_PROT);
        rdchk(dpdrh_pkg::STATUS_A_OFS, B_HOLD | B_COLD);

        // No probe at release, pin edge inside reset must not count
        do_reset(1'b0, 1'b0, 1'b1);
        pin(O_HOLD, 1'b0);
        rdchk(dpdrh_pkg::STATUS_A_OFS, 32'h0000_0000);
        rdchk(dpdrh_pkg::STATUS_B_OFS, B_HPA);
        probe_frame();
        rdchk(dpdrh_pkg::STATUS_B_OFS, B_HPA | B_SEEN);
        rdchk(dpdrh_pkg::IRQ_STAT_OFS, 32'h1 << dpdrh_pkg::EV_HOT);
        wr(dpdrh_pkg::STATUS_B_OFS, B_SEEN);
        rdchk(dpdrh_pkg::STATUS_B_OFS, B_HPA);

        // Pad taken away from debug on purpose, then handed back
        @(posedge hclk);
        pad_reassigned <= 1'b1;
        plugged <= 1'b0;
        repeat (3) @(posedge hclk);
        pad_reassigned <= 1'b0;
        rdchk(dpdrh_pkg::STATUS_B_OFS, 32'h0000_0000);
        probe_frame();
        rdchk(dpdrh_pkg::STATUS_B_OFS, 32'h0000_0000);
        do_reset(1'b0, 1'b0, 1'b0);
        rdchk(dpdrh_pkg::STATUS_B_OFS, B_HPA);
        summarize();
    end
endmodule // dpdrh_top_tb
